// file: rtl/wpt_top.sv
// watchdog prescaler: apb registers, tick divider, two-stage timeout counter
// assumes clock is the watchdog oscillator rate; apb master on the same clock
//
// Behaviour
// - prescale codes 0 to 9 give 2048 times two to the code ticks
// - divider select 3 divides the oscillator clock by seven
// - divider select 4 divides the oscillator clock by nine
// - early warning after one interval, timeout after two intervals
// - divider select 2 divides the oscillator clock by five
// - divider selects 5 and 6 divide by eleven and thirteen
`timescale 1ns/100ps
`include "wpt_regs.svh"
module wpt_top #(
   parameter int CNT_W = 22
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire wpt_pkg::wpt_apb_req_t apb_req,
   output wpt_pkg::wpt_apb_rsp_t apb_rsp,
   output logic early_warning,
   output logic timeout,
   output logic irq
);
   import wpt_pkg::*;
   wpt_ctrl_t ctrl_q, ctrl_d;
   logic [1:0] stat_q, stat_d, ien_q, ien_d;
   logic [31:0] rdata_q, rdata_d;
   logic err_d;
   logic rvalid_q, rvalid_d;
   logic early_q, early_d, tout_q, tout_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   wpt_state_t st_q, st_d;
   logic wr, rd, restart, tick, hit;
   logic [CNT_W-1:0] limit;

   assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign rd = apb_req.psel && apb_req.penable && !apb_req.pwrite;

   function automatic logic [CNT_W-1:0] ticks_for(input logic [3:0] code);
      logic [CNT_W-1:0] base;
      base = CNT_W'(`WPT_BASE_TICKS);
      if (code > `WPT_MAX_CODE) begin
         ticks_for = base << `WPT_MAX_CODE;
      end else begin
         ticks_for = base << code;
      end
   endfunction

   assign limit = ticks_for(ctrl_q.pre_sel);

   // register file
   always_comb begin
      ctrl_d = ctrl_q;
      ien_d = ien_q;
      stat_d = stat_q;
      rdata_d = rdata_q;
      err_d = 1'b0;
      rvalid_d = rd && !rvalid_q;
      restart = 1'b0;
      if (wr) begin
         unique case (apb_req.paddr)
            `WPT_CTRL_OFF: begin
               ctrl_d.pre_sel = apb_req.pwdata[`WPT_CTRL_PRE_LSB +: 4];
               ctrl_d.div_sel = apb_req.pwdata[`WPT_CTRL_DIV_LSB +: 3];
               restart = 1'b1;
            end
            `WPT_CLR_OFF: stat_d = stat_q & ~apb_req.pwdata[1:0];
            `WPT_IEN_OFF: ien_d = apb_req.pwdata[1:0];
            `WPT_RST_OFF: restart = (apb_req.pwdata == `WPT_RESTART_KEY);
            `WPT_STAT_OFF: err_d = 1'b1;
            default: err_d = 1'b1;
         endcase
      end
      if (rd) begin
         unique case (apb_req.paddr)
            `WPT_CTRL_OFF: rdata_d = {25'h0, ctrl_q.div_sel, ctrl_q.pre_sel};
            `WPT_STAT_OFF: rdata_d = {30'h0, stat_q};
            `WPT_IEN_OFF: rdata_d = {30'h0, ien_q};
            `WPT_CLR_OFF, `WPT_RST_OFF: rdata_d = 32'h00000000;
            default: begin
               rdata_d = 32'h00000000;
               err_d = 1'b1;
            end
         endcase
      end
      // set wins over clear
      if (early_d) begin
         stat_d[`WPT_STAT_EARLY] = 1'b1;
      end
      if (tout_d) begin
         stat_d[`WPT_STAT_TOUT] = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= wpt_ctrl_t'(7'(`WPT_CTRL_RST));
         ien_q <= 2'h0;
         stat_q <= 2'h0;
         rdata_q <= 32'h00000000;
         rvalid_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         ien_q <= ien_d;
         stat_q <= stat_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // reads take one wait state so that prdata comes from a flop
   assign apb_rsp.pready = !rd || rvalid_q;
   assign apb_rsp.prdata = rdata_q;
   assign apb_rsp.pslverr = err_d;

   wpt_tick_div u_div (
      .clock(clock),
      .rst_b(rst_b),
      .restart(restart),
      .div_sel(ctrl_q.div_sel),
      .tick(tick)
   );

   assign hit = tick && (cnt_q == limit - CNT_W'(1));

   // two-stage timeout
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      early_d = 1'b0;
      tout_d = 1'b0;
      if (restart) begin
         cnt_d = '0;
         st_d = WPT_IDLE;
      end else if (tick && st_q != WPT_FIRED) begin
         cnt_d = hit ? '0 : cnt_q + CNT_W'(1);
         if (hit) begin
            unique case (st_q)
               WPT_IDLE: begin
                  st_d = WPT_WARN;
                  early_d = 1'b1;
               end
               WPT_WARN: begin
                  st_d = WPT_FIRED;
                  tout_d = 1'b1;
               end
               default: st_d = WPT_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= WPT_IDLE;
         cnt_q <= '0;
         early_q <= 1'b0;
         tout_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         early_q <= early_d;
         tout_q <= tout_d;
      end
   end

   assign early_warning = early_q;
   assign timeout = tout_q;
   assign irq = |(stat_q & ien_q);

   int unsigned ticks_q;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ticks_q <= 0;
      end else if (restart) begin
         ticks_q <= 0;
      end else if (tick) begin
         ticks_q <= ticks_q + 1;
      end
   end

   early_count_a: assert property (@(posedge clock) disable iff (!rst_b)
      early_q |-> $past(ticks_q) + 1 == limit)
      else $error("early warning at wrong tick count");
   double_time_a: assert property (@(posedge clock) disable iff (!rst_b)
      tout_q |-> $past(ticks_q) + 1 == 2 * limit)
      else $error("timeout not at twice the interval");
   restart_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
      restart |=> cnt_q == '0 && st_q == WPT_IDLE)
      else $error("restart did not clear counter");
   div_five_a: assert property (@(posedge clock) disable iff (!rst_b || restart)
      tick && ctrl_q.div_sel == 3'd2 |=> (!tick)[*4] ##1 tick)
      else $error("divide by five tick spacing wrong");
   div_eleven_a: assert property (@(posedge clock) disable iff (!rst_b || restart)
      tick && ctrl_q.div_sel == 3'd5 |=> (!tick)[*8] ##1 (!tick)[*2] ##1 tick)
      else $error("divide by eleven tick spacing wrong");
   div_thirteen_a: assert property (@(posedge clock) disable iff (!rst_b || restart)
      tick && ctrl_q.div_sel == 3'd6 |=> (!tick)[*8] ##1 (!tick)[*4] ##1 tick)
      else $error("divide by thirteen tick spacing wrong");
   sticky_set_a: assert property (@(posedge clock) disable iff (!rst_b)
      early_q |-> stat_q[`WPT_STAT_EARLY])
      else $error("early event lost from status");
   irq_level_a: assert property (@(posedge clock) disable iff (!rst_b)
      (early_q && ien_q[`WPT_STAT_EARLY]) || (tout_q && ien_q[`WPT_STAT_TOUT]) |-> irq)
      else $error("enabled event did not raise interrupt");
   warn_before_a: assert property (@(posedge clock) disable iff (!rst_b)
      tout_q |-> $past(st_q) == WPT_WARN)
      else $error("timeout without early warning");
   early_c: cover property (@(posedge clock) disable iff (!rst_b) early_q);
   tout_c: cover property (@(posedge clock) disable iff (!rst_b) tout_q);
   restart_c: cover property (@(posedge clock) disable iff (!rst_b) restart && st_q == WPT_WARN);
endmodule

// file: inc/wpt_regs.svh
// register offsets, field positions, reset values and timing counts of the watchdog prescaler
// assumes an apb slave with 32-bit data, one aligned word per register
`ifndef WPT_REGS_SVH
`define WPT_REGS_SVH
`define WPT_CTRL_OFF 12'h000
`define WPT_STAT_OFF 12'h004
`define WPT_CLR_OFF 12'h008
`define WPT_IEN_OFF 12'h00C
`define WPT_RST_OFF 12'h010
`define WPT_CTRL_PRE_LSB 0
`define WPT_CTRL_DIV_LSB 4
`define WPT_CTRL_RST 32'h00000000
`define WPT_RESTART_KEY 32'h000000A5
`define WPT_BASE_TICKS 2048
`define WPT_MAX_CODE 4'h9
`define WPT_STAT_EARLY 0
`define WPT_STAT_TOUT 1
`endif

// file: inc/wpt_pkg.sv
// types shared by the watchdog prescaler and its divider
// assumes wpt_regs.svh for numeric constants
package wpt_pkg;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } wpt_apb_req_t;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } wpt_apb_rsp_t;
   typedef struct packed {
      logic [2:0] div_sel;
      logic [3:0] pre_sel;
   } wpt_ctrl_t;
   typedef enum logic [2:0] {
      WPT_IDLE = 3'b001,
      WPT_WARN = 3'b010,
      WPT_FIRED = 3'b100
   } wpt_state_t;
endpackage

// file: rtl/wpt_tick_div.sv
// divides the oscillator-rate clock into a watchdog tick enable
// assumes div_sel changes only together with a restart pulse
`timescale 1ns/100ps
module wpt_tick_div (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic restart,
   input wire logic [2:0] div_sel,
   output logic tick
);
   import wpt_pkg::*;
   logic [3:0] cnt_q, cnt_d;
   logic [3:0] ratio;

   function automatic logic [3:0] div_ratio(input logic [2:0] sel);
      unique case (sel)
         3'd2: div_ratio = 4'h5;
         3'd3: div_ratio = 4'h7;
         3'd4: div_ratio = 4'h9;
         3'd5: div_ratio = 4'hB;
         3'd6: div_ratio = 4'hD;
         default: div_ratio = 4'h1;
      endcase
   endfunction

   assign ratio = div_ratio(div_sel);

   always_comb begin
      cnt_d = cnt_q + 4'h1;
      if (restart || cnt_q >= ratio - 4'h1) begin
         cnt_d = 4'h0;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 4'h0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign tick = !restart && (cnt_q >= ratio - 4'h1);

   div_period_a: assert property (@(posedge clock) disable iff (!rst_b || restart)
      tick && div_sel == 3'd3 |=> (!tick)[*6] ##1 tick)
      else $error("divide by seven tick spacing wrong");
   div_nine_a: assert property (@(posedge clock) disable iff (!rst_b || restart)
      tick && div_sel == 3'd4 |=> (!tick)[*8] ##1 tick)
      else $error("divide by nine tick spacing wrong");
endmodule

// file: testbench/watchdog_prescale_timeout_bench.sv
// bench for the watchdog prescaler: divider and prescale rows, then restart, irq and apb cases
// assumes wpt_top answers writes at once and reads after one wait state
`timescale 1ns/100ps
`include "wpt_regs.svh"
module watchdog_prescale_timeout_bench;
   import wpt_pkg::*;
   typedef struct {logic [2:0] d; logic [3:0] c; int r;} wpt_row_t;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   wpt_apb_req_t req = '0;
   wpt_apb_rsp_t rsp;
   logic ew;
   logic to;
   logic irq;
   logic [31:0] rd;
   logic err;
   int n;
   int mismatches = 0;
   int tests_run = 0;
   // prescale codes stay within 0 to 9
   wpt_row_t rows [6] = '{'{3'h1, 4'h0, 1}, '{3'h2, 4'h0, 5}, '{3'h3, 4'h0, 7},
      '{3'h4, 4'h0, 9}, '{3'h5, 4'h0, 11}, '{3'h0, 4'h1, 1}};

   always #5 clock = ~clock;

   wpt_top u_dut (.clock(clock), .rst_b(rst_b), .apb_req(req), .apb_rsp(rsp),
      .early_warning(ew), .timeout(to), .irq(irq));

   task final_report;
      $display("counts: %0d compared, %0d wrong", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task chk_rng(input int g, input int lo, input int hi);
      tests_run++;
      if (g < lo || g > hi) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h..%h", $time, g, lo, hi);
      end
   endtask

   // one apb transfer; response and read data taken at the edge where pready is high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clock);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clock);
      req.penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clock);
         if (rsp.pready === 1'b1) break;
      end
      if (i == 20) begin
         mismatches++;
         final_report;
      end
      err = rsp.pslverr;
      rd = rsp.prdata;
      req <= '0;
   endtask

   // counts edges until early warning (sel 0) or timeout (sel 1) pulses
   task wait_pulse(input bit sel, output int c);
      for (c = 1; c < 40000; c++) begin
         @(posedge clock);
         if ((sel ? to : ew) === 1'b1) return;
      end
      mismatches++;
      final_report;
   endtask

   initial begin
      repeat (5) @(posedge clock);
      rst_b <= 1'b1;
      @(negedge clock);
      chk({ew, to, irq}, 32'h0);
      apb(1'b0, `WPT_CTRL_OFF, 32'h0);
      chk(rd, `WPT_CTRL_RST);
      $display("test reset done");
      foreach (rows[k]) begin
         apb(1'b1, `WPT_CTRL_OFF, {25'h0, rows[k].d, rows[k].c});
         wait_pulse(1'b0, n);
         chk_rng(n, ((2048 << rows[k].c) - 1) * rows[k].r,
            ((2048 << rows[k].c) + 1) * rows[k].r + 4);
         $display("test row %0d done", k);
      end
      apb(1'b1, `WPT_CTRL_OFF, 32'h00000069);
      repeat (60) @(posedge clock);
      apb(1'b0, `WPT_CTRL_OFF, 32'h0);
      chk(rd, 32'h00000069);
      chk(err, 1'b0);
      $display("test divide by thirteen done");
      apb(1'b1, `WPT_IEN_OFF, 32'h3);
      apb(1'b1, `WPT_CLR_OFF, 32'h3);
      apb(1'b1, `WPT_CTRL_OFF, {25'h0, 3'h1, 4'h0});
      repeat (1500) @(posedge clock);
      apb(1'b1, `WPT_RST_OFF, `WPT_RESTART_KEY);
      wait_pulse(1'b0, n);
      chk_rng(n, 2047, 2053);
      wait_pulse(1'b1, n);
      chk(n, 2048);
      $display("test restart and two stages done");
      @(negedge clock);
      chk(irq, 1'b1);
      apb(1'b0, `WPT_STAT_OFF, 32'h0);
      chk(rd, 32'h3);
      apb(1'b1, `WPT_IEN_OFF, 32'h0);
      @(negedge clock);
      chk(irq, 1'b0);
      apb(1'b1, `WPT_IEN_OFF, 32'h3);
      @(negedge clock);
      chk(irq, 1'b1);
      apb(1'b1, `WPT_CLR_OFF, 32'h3);
      @(negedge clock);
      chk(irq, 1'b0);
      apb(1'b0, `WPT_STAT_OFF, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk(err, 1'b1);
      $display("test irq and unmapped done");
      final_report;
   end
endmodule
